// *** hdl/tkrb_regs.vh ***
`ifndef TKRB_REGS_VH
`define TKRB_REGS_VH

// register word addresses
`define TKRB_ADDR_CONTROL      4'h0
`define TKRB_ADDR_PRE_COUNT    4'h1
`define TKRB_ADDR_PRE_RELOAD   4'h2
`define TKRB_ADDR_CNT_LOW      4'h3
`define TKRB_ADDR_CNT_HIGH     4'h4
`define TKRB_ADDR_REL_LOW      4'h5
`define TKRB_ADDR_REL_HIGH     4'h6
`define TKRB_ADDR_TK_SUBNODE   4'h7
`define TKRB_ADDR_SH_SUBNODE   4'h8
`define TKRB_ADDR_IRQ_STATUS   4'h9
`define TKRB_ADDR_IRQ_MASK     4'ha

// control bits
`define TKRB_CTL_RUN           0
`define TKRB_CTL_FIXED         1
`define TKRB_CTL_STEP_DOWN     2
`define TKRB_CTL_STEP_UP       3
`define TKRB_CTL_RESET         16'h0003

// timekeeper subnode bit pairs: enable even, request odd
`define TKRB_SN_PRE_EN         0
`define TKRB_SN_PRE_RQ         1
`define TKRB_SN_F0_EN          2
`define TKRB_SN_F0_RQ          3
`define TKRB_SN_F1_EN          4
`define TKRB_SN_F1_RQ          5
`define TKRB_SN_F2_EN          6
`define TKRB_SN_F2_RQ          7
`define TKRB_SN_F3_EN          8
`define TKRB_SN_F3_RQ          9

// shared subnode bits
`define TKRB_SH_COMB_RQ        0
`define TKRB_SH_COMB_EN        1
`define TKRB_SH_SEC_RQ         2
`define TKRB_SH_SEC_EN         3

// field limits
`define TKRB_PRE_TOP           16'hffff
`define TKRB_TOP10             10'h3ff
`define TKRB_TOP6              10'h03f
`define TKRB_ZERO16            16'h0000

`endif

// *** hdl/tkrb_timekeeper.v ***
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Function
// - run bit gates counting, control resets to 0003h
// - step-down bit decrements prescaler, self clears
// - step-up bit increments prescaler, self clears
// - 16-bit prescaler, overflow clocks counter, interrupts
// - 16-bit prescaler reload register, reset zero
// - low word: 10-bit fine, 6-bit coarse
// - high word holds 6-bit and 10-bit fields
// - low reload word mirrors low field layout
// - high reload word mirrors high field layout
// - subnode pairs enable and request per source
// - request shows raised; enable passes or blocks
// - shared subnode combined request and enable
// - second source bits are plain storage
// - request flags stay until software clears
// - prescaler reloads on overflow, both count up
// - overflows raise requests, enabled ones ORed
// - registers return to reset values only by hardware reset
`include "tkrb_regs.vh"

module tkrb_timekeeper (
	// clock and reset
	input  wire        clk,
	input  wire        reset,
	// count tick pin, asynchronous
	input  wire        count_tick,
	// register port
	input  wire [3:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [15:0] rdata,
	// interrupts
	output wire        irq,
	output wire        node_request
);

	function [10:0] tkrb_fld_step;
		input [9:0] v;
		input [9:0] rel;
		input [9:0] top;
		input       adv;
		begin
			if (!adv) begin
				tkrb_fld_step = {1'b0, v};
			end else if (v == top) begin
				tkrb_fld_step = {1'b1, rel};
			end else begin
				tkrb_fld_step = {1'b0, v + 10'h001};
			end
		end
	endfunction

	reg        tick_s1_q;
	reg        tick_s2_q;
	reg        tick_s3_q;
	reg        run_q;
	reg        up_q;
	reg        down_q;
	reg [15:0] pre_q;
	reg [15:0] pre_rel_q;
	reg [9:0]  f0_q;
	reg [5:0]  f1_q;
	reg [5:0]  f2_q;
	reg [9:0]  f3_q;
	reg [9:0]  r0_q;
	reg [5:0]  r1_q;
	reg [5:0]  r2_q;
	reg [9:0]  r3_q;
	reg [9:0]  sn_q;
	reg [3:0]  sh_q;
	reg [4:0]  st_q;
	reg [4:0]  mask_q;

	reg [15:0] pre_d;
	reg [15:0] rd_d;
	reg        up_d;
	reg        down_d;
	reg [9:0]  sn_d;
	reg [3:0]  sh_d;
	reg [4:0]  st_d;

	wire       w_ctl = wr && (addr == `TKRB_ADDR_CONTROL);
	wire       w_pre = wr && (addr == `TKRB_ADDR_PRE_COUNT);
	wire       w_prl = wr && (addr == `TKRB_ADDR_PRE_RELOAD);
	wire       w_cl  = wr && (addr == `TKRB_ADDR_CNT_LOW);
	wire       w_ch  = wr && (addr == `TKRB_ADDR_CNT_HIGH);
	wire       w_rl  = wr && (addr == `TKRB_ADDR_REL_LOW);
	wire       w_rh  = wr && (addr == `TKRB_ADDR_REL_HIGH);
	wire       w_sn  = wr && (addr == `TKRB_ADDR_TK_SUBNODE);
	wire       w_sh  = wr && (addr == `TKRB_ADDR_SH_SUBNODE);
	wire       w_msk = wr && (addr == `TKRB_ADDR_IRQ_MASK);
	wire       r_st  = rd && (addr == `TKRB_ADDR_IRQ_STATUS);

	// rising tick edge, read only past the first stage
	wire       tick    = tick_s2_q & ~tick_s3_q;
	wire       tick_go = tick & run_q;
	// a tick takes precedence, pending steps wait one more cycle
	wire       up_go   = up_q & ~tick_go;
	wire       down_go = down_q & ~tick_go & ~up_q;
	wire       adv     = tick_go | up_go;
	wire       pre_ovf = adv && (pre_q == `TKRB_PRE_TOP);

	wire [10:0] n0 = tkrb_fld_step(f0_q, r0_q, `TKRB_TOP10,
		pre_ovf);
	wire [10:0] n1 = tkrb_fld_step({4'h0, f1_q}, {4'h0, r1_q},
		`TKRB_TOP6, n0[10]);
	wire [10:0] n2 = tkrb_fld_step({4'h0, f2_q}, {4'h0, r2_q},
		`TKRB_TOP6, n1[10]);
	wire [10:0] n3 = tkrb_fld_step(f3_q, r3_q, `TKRB_TOP10,
		n2[10]);

	wire [4:0] ev = {n3[10], n2[10], n1[10], n0[10], pre_ovf};

	wire [4:0] sn_req = {sn_q[`TKRB_SN_F3_RQ], sn_q[`TKRB_SN_F2_RQ],
		sn_q[`TKRB_SN_F1_RQ], sn_q[`TKRB_SN_F0_RQ],
		sn_q[`TKRB_SN_PRE_RQ]};
	wire [4:0] sn_en = {sn_q[`TKRB_SN_F3_EN], sn_q[`TKRB_SN_F2_EN],
		sn_q[`TKRB_SN_F1_EN], sn_q[`TKRB_SN_F0_EN],
		sn_q[`TKRB_SN_PRE_EN]};
	wire       combined = |(sn_req & sn_en);

	assign node_request = sh_q[`TKRB_SH_COMB_RQ] &
		sh_q[`TKRB_SH_COMB_EN];
	assign irq = |(st_q & mask_q);

	always @* begin
		// software write beats a count in the same cycle
		if (w_pre) begin
			pre_d = wdata;
		end else if (pre_ovf) begin
			pre_d = pre_rel_q;
		end else if (adv) begin
			pre_d = pre_q + 16'h0001;
		end else if (down_go) begin
			pre_d = pre_q - 16'h0001;
		end else begin
			pre_d = pre_q;
		end
		up_d   = (up_q & ~up_go) |
			(w_ctl & wdata[`TKRB_CTL_STEP_UP]);
		down_d = (down_q & ~down_go) |
			(w_ctl & wdata[`TKRB_CTL_STEP_DOWN]);
		// set wins over a clearing write
		sn_d = w_sn ? wdata[9:0] : sn_q;
		sn_d[`TKRB_SN_PRE_RQ] = sn_d[`TKRB_SN_PRE_RQ] | ev[0];
		sn_d[`TKRB_SN_F0_RQ]  = sn_d[`TKRB_SN_F0_RQ] | ev[1];
		sn_d[`TKRB_SN_F1_RQ]  = sn_d[`TKRB_SN_F1_RQ] | ev[2];
		sn_d[`TKRB_SN_F2_RQ]  = sn_d[`TKRB_SN_F2_RQ] | ev[3];
		sn_d[`TKRB_SN_F3_RQ]  = sn_d[`TKRB_SN_F3_RQ] | ev[4];
		// second source has nothing wired in, storage only
		sh_d = w_sh ? wdata[3:0] : sh_q;
		sh_d[`TKRB_SH_COMB_RQ] = sh_d[`TKRB_SH_COMB_RQ] |
			combined;
		st_d = (r_st ? 5'h00 : st_q) | ev;
		rd_d = `TKRB_ZERO16;
		if (addr == `TKRB_ADDR_CONTROL) begin
			rd_d = {12'h000, up_q, down_q, 1'b1, run_q};
		end else if (addr == `TKRB_ADDR_PRE_COUNT) begin
			rd_d = pre_q;
		end else if (addr == `TKRB_ADDR_PRE_RELOAD) begin
			rd_d = pre_rel_q;
		end else if (addr == `TKRB_ADDR_CNT_LOW) begin
			rd_d = {f1_q, f0_q};
		end else if (addr == `TKRB_ADDR_CNT_HIGH) begin
			rd_d = {f3_q, f2_q};
		end else if (addr == `TKRB_ADDR_REL_LOW) begin
			rd_d = {r1_q, r0_q};
		end else if (addr == `TKRB_ADDR_REL_HIGH) begin
			rd_d = {r3_q, r2_q};
		end else if (addr == `TKRB_ADDR_TK_SUBNODE) begin
			rd_d = {6'h00, sn_q};
		end else if (addr == `TKRB_ADDR_SH_SUBNODE) begin
			rd_d = {12'h000, sh_q};
		end else if (addr == `TKRB_ADDR_IRQ_STATUS) begin
			rd_d = {11'h000, st_q};
		end else if (addr == `TKRB_ADDR_IRQ_MASK) begin
			rd_d = {11'h000, mask_q};
		end
		if (!rd) begin
			rd_d = `TKRB_ZERO16;
		end
	end

	// only hardware reset loads the reset values
	always @(posedge clk) begin
		if (reset) begin
			tick_s1_q <= 1'b0;
			tick_s2_q <= 1'b0;
			tick_s3_q <= 1'b0;
			run_q     <= 1'b1;
			up_q      <= 1'b0;
			down_q    <= 1'b0;
			pre_q     <= `TKRB_ZERO16;
			pre_rel_q <= `TKRB_ZERO16;
			f0_q      <= 10'h000;
			f1_q      <= 6'h00;
			f2_q      <= 6'h00;
			f3_q      <= 10'h000;
			r0_q      <= 10'h000;
			r1_q      <= 6'h00;
			r2_q      <= 6'h00;
			r3_q      <= 10'h000;
			sn_q      <= 10'h000;
			sh_q      <= 4'h0;
			st_q      <= 5'h00;
			mask_q    <= 5'h00;
			rdata     <= `TKRB_ZERO16;
		end else begin
			tick_s1_q <= count_tick;
			tick_s2_q <= tick_s1_q;
			tick_s3_q <= tick_s2_q;
			if (w_ctl) begin
				run_q <= wdata[`TKRB_CTL_RUN];
			end
			up_q   <= up_d;
			down_q <= down_d;
			pre_q  <= pre_d;
			if (w_prl) begin
				pre_rel_q <= wdata;
			end
			f0_q <= w_cl ? wdata[9:0] : n0[9:0];
			f1_q <= w_cl ? wdata[15:10] : n1[5:0];
			f2_q <= w_ch ? wdata[5:0] : n2[5:0];
			f3_q <= w_ch ? wdata[15:6] : n3[9:0];
			if (w_rl) begin
				r0_q <= wdata[9:0];
				r1_q <= wdata[15:10];
			end
			if (w_rh) begin
				r2_q <= wdata[5:0];
				r3_q <= wdata[15:6];
			end
			sn_q <= sn_d;
			sh_q <= sh_d;
			st_q <= st_d;
			if (w_msk) begin
				mask_q <= wdata[4:0];
			end
			rdata <= rd_d;
		end
	end

endmodule

// *** verif/tkrb_timekeeper_monitor.sv ***
`timescale 1ns/10ps
module tkrb_timekeeper_monitor (
	// clock and reset
	input wire        clk,
	input wire        reset,
	// register port and outputs
	input wire        count_tick,
	input wire [3:0]  addr,
	input wire [15:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [15:0] rdata,
	input wire        irq,
	input wire        node_request
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// reload write, idle cycle, then read of the same word
	sequence s_reload_wr;
		wr && addr == 4'h2;
	endsequence
	sequence s_reload_rd;
		rd && addr == 4'h2;
	endsequence
	a_reload_echo: assert property (s_reload_wr ##2 s_reload_rd
		|=> rdata == $past(wdata, 3)) else $error("reload word lost");
	a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (rd && addr > 4'ha
		|=> rdata == 16'h0000) else $error("unmapped read not zero");
	a_ctl_fixed: assert property (rd && addr == 4'h0
		|=> rdata[1] && rdata[15:4] == 12'h000)
		else $error("control fixed bits wrong");
	a_subnode_top: assert property (rd && addr == 4'h7
		|=> rdata[15:10] == 6'h00) else $error("subnode unused bits set");
	a_shared_top: assert property (rd && addr == 4'h8
		|=> rdata[15:4] == 12'h000) else $error("shared unused bits set");
	a_node_off: assert property (wr && addr == 4'h8 && !wdata[1]
		|=> !node_request) else $error("node request while disabled");
	a_irq_off: assert property (wr && addr == 4'ha && wdata[4:0] == 5'h00
		|=> !irq) else $error("irq while all masked");
endmodule

bind tkrb_timekeeper tkrb_timekeeper_monitor mon_u (.clk(clk), .reset(reset),
	.count_tick(count_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .irq(irq), .node_request(node_request));

// *** verif/test_tkrb_timekeeper.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_tkrb_timekeeper;
	logic        clk = 0;
	logic        reset = 1;
	logic        count_tick = 0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 0;
	logic        rd = 0;
	wire  [15:0] rdata;
	wire         irq;
	wire         node_request;
	int          fail_count = 0;
	int          num_checks = 0;
	always #20 clk = ~clk;
	tkrb_timekeeper dut_u (.clk(clk), .reset(reset), .count_tick(count_tick),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.irq(irq), .node_request(node_request));
	task wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
		#1;
	endtask
	task rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1;
		`CHK($sformatf("reg%0h", a), e, rdata)
	endtask
	// wide pulse, the pin passes a three-flop synchroniser
	task tick;
		@(posedge clk);
		count_tick <= 1;
		repeat (3) @(posedge clk);
		count_tick <= 0;
		repeat (8) @(posedge clk);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task t_reset;
		for (int i = 0; i < 12; i++)
			rd_chk(i[3:0], i == 0 ? 16'h0003 : 16'h0000);
		$display("reset values done");
	endtask
	task t_rw;
		for (int i = 1; i < 7; i++) begin
			wr_reg(i[3:0], 16'ha5c3 ^ i[15:0]);
			rd_chk(i[3:0], 16'ha5c3 ^ i[15:0]);
			wr_reg(i[3:0], 16'h0000);
		end
		wr_reg(4'h7, 16'h03ff);
		rd_chk(4'h7, 16'h03ff);
		wr_reg(4'h7, 16'h0000);
		wr_reg(4'h8, 16'h0000);
		wr_reg(4'h8, 16'h000c);
		rd_chk(4'h8, 16'h000c);
		wr_reg(4'h8, 16'h0000);
		wr_reg(4'hb, 16'hffff);
		rd_chk(4'hb, 16'h0000);
		$display("read write done");
	endtask
	task t_step;
		wr_reg(4'h0, 16'h0000);
		rd_chk(4'h0, 16'h0002);
		wr_reg(4'h1, 16'h0010);
		wr_reg(4'h0, 16'h0008);
		rd_chk(4'h1, 16'h0011);
		rd_chk(4'h0, 16'h0002);
		wr_reg(4'h0, 16'h0004);
		rd_chk(4'h1, 16'h0010);
		wr_reg(4'h1, 16'h0000);
		wr_reg(4'h0, 16'h0004);
		rd_chk(4'h1, 16'hffff);
		rd_chk(4'h0, 16'h0002);
		rd_chk(4'h7, 16'h0000);
		$display("step done");
	endtask
	task t_tick;
		wr_reg(4'h1, 16'hfffe);
		tick;
		rd_chk(4'h1, 16'hfffe);
		wr_reg(4'h0, 16'h0001);
		wr_reg(4'h2, 16'h1234);
		wr_reg(4'h5, 16'h0402);
		wr_reg(4'h3, 16'hffff);
		wr_reg(4'ha, 16'h001f);
		tick;
		rd_chk(4'h1, 16'hffff);
		`CHK("irq", 1'b0, irq)
		tick;
		rd_chk(4'h1, 16'h1234);
		rd_chk(4'h3, 16'h0402);
		rd_chk(4'h4, 16'h0001);
		rd_chk(4'h7, 16'h002a);
		`CHK("irq", 1'b1, irq)
		rd_chk(4'h9, 16'h0007);
		rd_chk(4'h9, 16'h0000);
		`CHK("irq", 1'b0, irq)
		rd_chk(4'h7, 16'h002a);
		wr_reg(4'h7, 16'h002b);
		rd_chk(4'h8, 16'h0001);
		wr_reg(4'h8, 16'h0003);
		`CHK("node", 1'b1, node_request)
		wr_reg(4'h7, 16'h0000);
		wr_reg(4'h8, 16'h0002);
		`CHK("node", 1'b0, node_request)
		rd_chk(4'h8, 16'h0002);
		wr_reg(4'ha, 16'h0000);
		$display("tick done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		reset <= 0;
		t_reset;
		t_rw;
		t_step;
		t_tick;
		give_verdict;
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		give_verdict;
	end
endmodule
